// ---- hw/hpi_fifo_mem.sv ----
// storage of the interrupt queue: one write port, registered read port
// assumes the caller keeps pointers and never writes while full
module hpi_fifo_mem #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 64,
    parameter int AW    = $clog2(DEPTH)
) (
    // clock
    input  wire logic             clock,
    input  wire logic             clk_en,
    // write side
    input  wire logic             wr_en,
    input  wire logic [AW-1:0]    wr_addr,
    input  wire logic [WIDTH-1:0] wr_data,
    // read side
    input  wire logic [AW-1:0]    rd_addr,
    output logic      [WIDTH-1:0] rd_data
);
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge clock) begin
        if (clk_en && wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clock) begin
        if (clk_en) begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule

// ---- hw/hpi_top.sv ----
// host port, device reset sequencer, interrupt queue and test access port
// assumes pins are asynchronous to clock; open-drain pins resolved outside
`include "hpi_cfg.svh"
module hpi_top #(
    parameter int FIFO_DEPTH = `HPI_FIFO_DEPTH,
    parameter int AW         = $clog2(FIFO_DEPTH)
) (
    // clock and reset
    input  wire logic                     clock,
    input  wire logic                     rstn,
    input  wire logic                     clk_en,
    // device reset and init walk
    input  wire logic                     device_reset_n,
    output logic                          standby,
    output logic                          init_busy,
    output logic                          init_we,
    output logic [`HPI_ADDR_W-1:0]        init_index,
    // host bus pins
    input  wire logic                     chip_select_n,
    input  wire logic                     data_strobe_n,
    input  wire logic                     read_not_write,
    input  wire logic [`HPI_ADDR_W-1:0]   addr,
    input  wire logic [`HPI_DATA_W-1:0]   data_in,
    output logic      [`HPI_DATA_W-1:0]   data_out,
    output logic                          data_oe_n,
    output logic                          transfer_ack_n,
    output logic                          transfer_ack_oe_n,
    output logic                          interrupt_request_n,
    output logic                          interrupt_request_oe_n,
    // core register access
    output logic                          reg_req,
    output logic                          reg_write,
    output logic [`HPI_ADDR_W-1:0]        reg_addr,
    output logic [`HPI_DATA_W-1:0]        reg_wdata,
    input  wire logic [`HPI_DATA_W-1:0]   reg_rdata,
    input  wire logic                     reg_ack,
    // channel interrupt events
    input  wire logic                     irq_push,
    input  wire logic [`HPI_DATA_W-1:0]   irq_code,
    output logic                          irq_full,
    // test access port
    input  wire logic                     tck,
    input  wire logic                     tms,
    input  wire logic                     tdi,
    input  wire logic                     test_reset_n,
    output logic                          tdo,
    output logic                          tdo_oe_n
);
    import hpi_pkg::*;

    localparam int SW = 26;

    // three-stage pin synchroniser, value taken when stages two and three agree
    logic [SW-1:0] s1_q, s2_q, s3_q, f_q;
    logic          dev_rst_f, cs_f, ds_f, rw_f, tck_f, tms_f, tdi_f;
    logic [10:0]   addr_f;
    logic [7:0]    din_f;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            s1_q <= `HPI_PIN_IDLE;
            s2_q <= `HPI_PIN_IDLE;
            s3_q <= `HPI_PIN_IDLE;
            f_q  <= `HPI_PIN_IDLE;
        end else if (clk_en) begin
            s1_q <= {device_reset_n, chip_select_n, data_strobe_n, read_not_write,
                     addr, data_in, tck, tms, tdi};
            s2_q <= s1_q;
            s3_q <= s2_q;
            f_q  <= (s2_q & s3_q) | (f_q & (s2_q ^ s3_q));
        end
    end
    assign {dev_rst_f, cs_f, ds_f, rw_f, addr_f, din_f, tck_f, tms_f, tdi_f} = f_q;

    // device reset, standby and init walk
    logic                    dev_prev_q;
    logic [`HPI_ADDR_W-1:0]  init_cnt_q;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            dev_prev_q <= 1'b0;
            standby    <= 1'b1;
            init_busy  <= 1'b0;
            init_we    <= 1'b0;
            init_index <= '0;
            init_cnt_q <= '0;
        end else if (clk_en) begin
            dev_prev_q <= dev_rst_f;
            standby    <= !dev_rst_f;
            init_we    <= 1'b0;
            if (!dev_rst_f) begin
                init_busy  <= 1'b0;
                init_cnt_q <= '0;
            end else if (!dev_prev_q) begin
                init_busy  <= 1'b1;
                init_cnt_q <= '0;
            end else if (init_busy) begin
                init_we    <= 1'b1;
                init_index <= init_cnt_q;
                init_cnt_q <= init_cnt_q + 11'h001;
                if (init_cnt_q == `HPI_INIT_COUNT - 11'h001) begin
                    init_busy <= 1'b0;
                end
            end
        end
    end

    // interrupt queue pointers; storage lives in the memory module
    logic [AW-1:0] wr_ptr_q, rd_ptr_q;
    logic [AW:0]   count_q;
    logic          push, pop;
    logic [7:0]    mem_rdata;

    assign push = irq_push && !irq_full && dev_rst_f;

    hpi_fifo_mem #(.WIDTH(`HPI_DATA_W), .DEPTH(FIFO_DEPTH), .AW(AW)) u_mem (
        .clock   (clock),
        .clk_en  (clk_en),
        .wr_en   (push),
        .wr_addr (wr_ptr_q),
        .wr_data (irq_code),
        .rd_addr (rd_ptr_q),
        .rd_data (mem_rdata)
    );

    // push and pop in one cycle leave the count alone; a push while full is dropped even if a pop comes in the same cycle
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
            irq_full <= 1'b0;
        end else if (clk_en) begin
            if (!dev_rst_f) begin
                wr_ptr_q <= '0;
                rd_ptr_q <= '0;
                count_q  <= '0;
                irq_full <= 1'b0;
            end else begin
                if (push) begin
                    wr_ptr_q <= wr_ptr_q + 1'b1;
                end
                if (pop) begin
                    rd_ptr_q <= rd_ptr_q + 1'b1;
                end
                count_q  <= count_q + (AW+1)'(push) - (AW+1)'(pop);
                irq_full <= (count_q + (AW+1)'(push) - (AW+1)'(pop)) == (AW+1)'(FIFO_DEPTH);
            end
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            interrupt_request_n    <= 1'b0;
            interrupt_request_oe_n <= 1'b1;
        end else if (clk_en) begin
            interrupt_request_oe_n <= (count_q == '0);
        end
    end

    // host port: 8-bit data, 11-bit address, open-drain acknowledge
    hpi_host_st_t host_q;
    logic         rw_lat_q, fifo_empty_lat_q;
    logic         access, access_end;

    assign access     = !cs_f && !ds_f;
    assign access_end = cs_f || ds_f;
    assign pop        = clk_en && (host_q == H_FIFO_RD) && !fifo_empty_lat_q;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            host_q            <= H_IDLE;
            rw_lat_q          <= 1'b1;
            fifo_empty_lat_q  <= 1'b1;
            reg_req           <= 1'b0;
            reg_write         <= 1'b0;
            reg_addr          <= '0;
            reg_wdata         <= '0;
            data_out          <= '0;
            data_oe_n         <= 1'b1;
            transfer_ack_n    <= 1'b0;
            transfer_ack_oe_n <= 1'b1;
        end else if (clk_en) begin
            reg_req <= 1'b0;
            if (!dev_rst_f) begin
                host_q            <= H_IDLE;
                data_oe_n         <= 1'b1;
                transfer_ack_oe_n <= 1'b1;
            end else begin
                case (host_q)
                    H_IDLE: begin
                        if (access && !init_busy && !standby) begin
                            rw_lat_q  <= rw_f;
                            reg_addr  <= addr_f;
                            reg_wdata <= din_f;
                            if (rw_f && addr_f == `HPI_IRQ_FIFO_ADDR) begin
                                fifo_empty_lat_q <= (count_q == '0);
                                host_q           <= H_FIFO_RD;
                            end else begin
                                reg_req   <= 1'b1;
                                reg_write <= !rw_f;
                                host_q    <= H_WAIT_CORE;
                            end
                        end
                    end
                    H_WAIT_CORE: begin
                        if (reg_ack) begin
                            data_out          <= reg_rdata;
                            data_oe_n         <= !rw_lat_q;
                            transfer_ack_oe_n <= 1'b0;
                            host_q            <= H_ACK;
                        end else if (access_end) begin
                            host_q <= H_IDLE;
                        end
                    end
                    H_FIFO_RD: begin
                        data_out          <= fifo_empty_lat_q ? `HPI_EMPTY_CODE : mem_rdata;
                        data_oe_n         <= 1'b0;
                        transfer_ack_oe_n <= 1'b0;
                        host_q            <= H_ACK;
                    end
                    H_ACK: begin
                        if (access_end) begin
                            data_oe_n         <= 1'b1;
                            transfer_ack_oe_n <= 1'b1;
                            host_q            <= H_IDLE;
                        end
                    end
                    default: host_q <= H_IDLE;
                endcase
            end
        end
    end

    // test access port, clocked by edges of the synchronised test clock
    function automatic hpi_tap_st_t tap_next(input hpi_tap_st_t s, input logic m);
        case (s)
            T_RESET:    tap_next = m ? T_RESET    : T_IDLE;
            T_IDLE:     tap_next = m ? T_SEL_DR   : T_IDLE;
            T_SEL_DR:   tap_next = m ? T_SEL_IR   : T_CAP_DR;
            T_CAP_DR:   tap_next = m ? T_EXIT1_DR : T_SHIFT_DR;
            T_SHIFT_DR: tap_next = m ? T_EXIT1_DR : T_SHIFT_DR;
            T_EXIT1_DR: tap_next = m ? T_UPD_DR   : T_PAUSE_DR;
            T_PAUSE_DR: tap_next = m ? T_EXIT2_DR : T_PAUSE_DR;
            T_EXIT2_DR: tap_next = m ? T_UPD_DR   : T_SHIFT_DR;
            T_UPD_DR:   tap_next = m ? T_SEL_DR   : T_IDLE;
            T_SEL_IR:   tap_next = m ? T_RESET    : T_CAP_IR;
            T_CAP_IR:   tap_next = m ? T_EXIT1_IR : T_SHIFT_IR;
            T_SHIFT_IR: tap_next = m ? T_EXIT1_IR : T_SHIFT_IR;
            T_EXIT1_IR: tap_next = m ? T_UPD_IR   : T_PAUSE_IR;
            T_PAUSE_IR: tap_next = m ? T_EXIT2_IR : T_PAUSE_IR;
            T_EXIT2_IR: tap_next = m ? T_UPD_IR   : T_SHIFT_IR;
            default:    tap_next = m ? T_SEL_DR   : T_IDLE;
        endcase
    endfunction

    // test reset acts without the clock; it is a reset pin, not data
    logic                 tap_arst_n, tck_prev_q, tck_rise, tck_fall;
    hpi_tap_st_t          tap_q;
    logic [`HPI_IR_W-1:0] ir_q, ir_sh_q;
    logic [31:0]          dr_sh_q;

    assign tap_arst_n = rstn && test_reset_n;
    assign tck_rise   = tck_f && !tck_prev_q;
    assign tck_fall   = !tck_f && tck_prev_q;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            tck_prev_q <= 1'b0;
        end else if (clk_en) begin
            tck_prev_q <= tck_f;
        end
    end

    always_ff @(posedge clock or negedge tap_arst_n) begin
        if (!tap_arst_n) begin
            tap_q   <= T_RESET;
            ir_q    <= `HPI_IR_IDCODE;
            ir_sh_q <= '0;
            dr_sh_q <= '0;
        end else if (clk_en && tck_rise) begin
            tap_q <= tap_next(tap_q, tms_f);
            case (tap_q)
                T_RESET:    ir_q    <= `HPI_IR_IDCODE;
                T_CAP_IR:   ir_sh_q <= `HPI_IR_CAPTURE;
                T_SHIFT_IR: ir_sh_q <= {tdi_f, ir_sh_q[`HPI_IR_W-1:1]};
                T_UPD_IR:   ir_q    <= ir_sh_q;
                T_CAP_DR:   dr_sh_q <= (ir_q == `HPI_IR_IDCODE) ? `HPI_IDCODE : 32'h0000_0000;
                T_SHIFT_DR: begin
                    if (ir_q == `HPI_IR_IDCODE) begin
                        dr_sh_q <= {tdi_f, dr_sh_q[31:1]};
                    end else begin
                        dr_sh_q <= {31'h0000_0000, tdi_f}; // bypass path
                    end
                end
                default: ;
            endcase
        end
    end

    // output updates half a test clock after the shift so the tester samples mid-bit
    always_ff @(posedge clock or negedge tap_arst_n) begin
        if (!tap_arst_n) begin
            tdo      <= 1'b0;
            tdo_oe_n <= 1'b1;
        end else if (clk_en && tck_fall) begin
            tdo      <= (tap_q == T_SHIFT_IR) ? ir_sh_q[0] : dr_sh_q[0];
            tdo_oe_n <= !(tap_q == T_SHIFT_IR || tap_q == T_SHIFT_DR);
        end
    end

    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    sequence s_acked;
        host_q == H_ACK && !transfer_ack_oe_n;
    endsequence
    sequence s_access_end;
        access_end && clk_en && dev_rst_f;
    endsequence

    a_tdo_fall_only: assert property ($changed(tdo) && test_reset_n |-> $past(tck_fall))
        else $error("test output moved without a falling test clock");
    a_tdo_hiz_idle: assert property (!tdo_oe_n && test_reset_n
                                     |-> tap_q inside {T_SHIFT_IR, T_SHIFT_DR,
                                                       T_EXIT1_IR, T_EXIT1_DR})
        else $error("test output driven outside a shift");
    a_trst_tlr: assert property (!test_reset_n |-> tap_q == T_RESET && tdo_oe_n)
        else $error("test controller not held in reset");
    a_standby_hold: assert property (!dev_rst_f && clk_en
                                     |=> standby && transfer_ack_oe_n && !init_busy)
        else $error("device reset did not hold standby");
    a_init_walk: assert property ($rose(dev_rst_f) && clk_en ##1 clk_en
                                  |=> init_busy && !standby)
        else $error("init walk did not start after device reset");
    a_irq_pending: assert property (count_q != '0 && clk_en |=> !interrupt_request_oe_n)
        else $error("pending interrupt not signalled");
    a_irq_release: assert property ($rose(interrupt_request_oe_n) |-> $past(count_q) == '0)
        else $error("interrupt released while entries remain");
    a_read_drives: assert property (!data_oe_n |-> rw_lat_q && host_q == H_ACK)
        else $error("data bus driven outside a read acknowledge");
    a_ack_done: assert property ($fell(transfer_ack_oe_n)
                                 |-> $past(host_q) inside {H_WAIT_CORE, H_FIFO_RD})
        else $error("acknowledge without finished transfer");
    a_ack_release: assert property (s_acked ##0 s_access_end
                                    |=> transfer_ack_oe_n && data_oe_n ##1 host_q == H_IDLE
                                        || !clk_en)
        else $error("acknowledge held after access ended");
endmodule

// ---- inc/hpi_cfg.svh ----
// constants of the host port, reset sequencer, interrupt queue and test port
// assumes a single core clock; pins arrive unsynchronised
//
// Overview of operation
// - Test data output changes only on the falling test clock edge.
// - Test data output is not driven unless an instruction or data shift runs.
// - Low test reset forces the test controller to Test-Logic-Reset immediately.
// - While device reset is low the device sits in reset and standby.
// - After device reset rises an init walk presets every control register.
// - Interrupt request output pulls low whenever a channel interrupt is pending.
// - Interrupt request releases only once the interrupt queue is read empty. The code also releases it when device reset low clears the queue.
// - Read/write decides whether the device drives or samples the data lines.
// - Device pulls transfer acknowledge low once the transfer has finished.
// - All register transfers use the 8-bit bidirectional data bus.
`ifndef HPI_CFG_SVH
`define HPI_CFG_SVH

`define HPI_ADDR_W        11
`define HPI_DATA_W        8
// sync stages start at pin idle levels
`define HPI_PIN_IDLE      26'h1c00003
`define HPI_IRQ_FIFO_ADDR 11'h7ff
`define HPI_EMPTY_CODE    8'h00
`define HPI_INIT_COUNT    11'h400
`define HPI_FIFO_DEPTH    64
`define HPI_IR_W          4
`define HPI_IR_IDCODE     4'h1
`define HPI_IR_BYPASS     4'hf
`define HPI_IR_CAPTURE    4'h1
`define HPI_IDCODE        32'h0000_0001

`endif

// ---- inc/hpi_pkg.sv ----
// types shared by the host port design
// assumes hpi_cfg.svh for numeric constants
package hpi_pkg;
    typedef enum logic [1:0] {
        H_IDLE, H_WAIT_CORE, H_FIFO_RD, H_ACK
    } hpi_host_st_t;

    typedef enum logic [3:0] {
        T_RESET, T_IDLE, T_SEL_DR, T_CAP_DR, T_SHIFT_DR, T_EXIT1_DR, T_PAUSE_DR,
        T_EXIT2_DR, T_UPD_DR, T_SEL_IR, T_CAP_IR, T_SHIFT_IR, T_EXIT1_IR,
        T_PAUSE_IR, T_EXIT2_IR, T_UPD_IR
    } hpi_tap_st_t;
endpackage

// ---- sim/hpi_host_model.sv ----
// host processor model for the asynchronous byte-wide register port
// assumes the core clock paces the host; the ack pin has a pull-up
module hpi_host_model (
    // clock
    input  wire logic        clock,
    // device answers
    input  wire logic        transfer_ack_oe_n,
    input  wire logic        data_oe_n,
    input  wire logic [7:0]  data_out,
    // bus pins
    output logic             chip_select_n,
    output logic             data_strobe_n,
    output logic             read_not_write,
    output logic [10:0]      addr,
    output logic [7:0]       data_in
);
    timeunit 1ns / 100ps;
    initial begin
        chip_select_n = 1'b1;
        data_strobe_n = 1'b1;
        read_not_write = 1'b1;
        addr = 11'h000;
        data_in = 8'h00;
    end

    // n: cycles until ack (0 if it never came), rel: cycles until ack and data let go
    task automatic access(input logic rnw, input logic [10:0] a, input logic [7:0] wd,
                          output logic [7:0] rd, output logic drv, output int n,
                          output int rel);
        n = 0;
        rel = 0;
        @(posedge clock);
        #1;
        read_not_write = rnw;
        addr = a;
        data_in = rnw ? ~data_in : wd;
        chip_select_n = 1'b0;
        data_strobe_n = 1'b0;
        while (n < 300 && transfer_ack_oe_n !== 1'b0) begin
            @(posedge clock);
            n++;
        end
        rd = data_out;
        drv = (data_oe_n === 1'b0);
        if (n >= 300) n = 0;
        #1;
        data_strobe_n = 1'b1;
        chip_select_n = 1'b1;
        data_in = ~data_in;
        while (rel < 20 && !(transfer_ack_oe_n === 1'b1 && data_oe_n === 1'b1)) begin
            @(posedge clock);
            rel++;
        end
        repeat (2) @(posedge clock);
    endtask

    // strobe with select left high; a correct port stays silent
    task automatic stray(input int k, output logic seen);
        seen = 1'b0;
        @(posedge clock);
        #1;
        data_strobe_n = 1'b0;
        repeat (k) begin
            @(posedge clock);
            if (transfer_ack_oe_n === 1'b0) seen = 1'b1;
        end
        #1;
        data_strobe_n = 1'b1;
        repeat (2) @(posedge clock);
    endtask
endmodule

// ---- sim/hpi_top_tb_top.sv ----
// self-checking bench for the host port, reset walk, interrupt queue and test port
// assumes hpi_host_model as the processor; the core side is modelled here
`include "hpi_cfg.svh"
module hpi_top_tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    logic        clock, rstn, device_reset_n, reg_ack, irq_push, tck, tms, tdi, test_reset_n;
    logic        chip_select_n, data_strobe_n, read_not_write, last_wr;
    logic        standby, init_busy, init_we, data_oe_n, transfer_ack_oe_n;
    logic        interrupt_request_oe_n, reg_req, reg_write, tdo, tdo_oe_n, irq_full;
    logic [10:0] addr, init_index, reg_addr, last_addr;
    logic [7:0]  data_in, data_out, reg_wdata, reg_rdata, irq_code, core_data, last_wd;
    int          failures, total_checks, core_cnt, ack_delay, req_cnt;

    hpi_top hpi_top_i (.clock(clock), .rstn(rstn), .clk_en(1'b1),
        .device_reset_n(device_reset_n), .standby(standby), .init_busy(init_busy),
        .init_we(init_we), .init_index(init_index), .chip_select_n(chip_select_n),
        .data_strobe_n(data_strobe_n), .read_not_write(read_not_write), .addr(addr),
        .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n), .transfer_ack_n(),
        .transfer_ack_oe_n(transfer_ack_oe_n), .interrupt_request_n(),
        .interrupt_request_oe_n(interrupt_request_oe_n), .reg_req(reg_req),
        .reg_write(reg_write), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_ack(reg_ack), .irq_push(irq_push), .irq_code(irq_code),
        .irq_full(irq_full), .tck(tck), .tms(tms), .tdi(tdi), .test_reset_n(test_reset_n),
        .tdo(tdo), .tdo_oe_n(tdo_oe_n));

    hpi_host_model hpi_host_model_i (.clock(clock), .transfer_ack_oe_n(transfer_ack_oe_n),
        .data_oe_n(data_oe_n), .data_out(data_out), .chip_select_n(chip_select_n),
        .data_strobe_n(data_strobe_n), .read_not_write(read_not_write), .addr(addr),
        .data_in(data_in));

    always #2 clock = ~clock;

    // core side: answers each request after ack_delay cycles
    always @(posedge clock) begin
        #1;
        reg_ack = 1'b0;
        reg_rdata = ~core_data;
        if (core_cnt == 1) begin
            reg_ack = 1'b1;
            reg_rdata = core_data;
        end
        if (core_cnt != 0) core_cnt--;
        if (reg_req === 1'b1) begin
            core_cnt = ack_delay;
            req_cnt++;
            last_wr = reg_write;
            last_addr = reg_addr;
            last_wd = reg_wdata;
        end
    end

    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic chk_flag(input string what, input logic exp, input logic got);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic chk_val(input string what, input logic [39:0] exp, input logic [39:0] got);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic t_standby();
        logic [7:0] rd;
        logic drv;
        int n, rel, r0;
        step(10);
        chk_flag("standby", 1'b1, standby);
        chk_flag("init busy", 1'b0, init_busy);
        chk_flag("tdo drive", 1'b1, tdo_oe_n);
        r0 = req_cnt;
        hpi_host_model_i.access(1'b0, 11'h001, 8'h77, rd, drv, n, rel);
        chk_val("ack in standby", 0, n);
        chk_val("core req in standby", r0, req_cnt);
    endtask

    task automatic t_init();
        int cnt, bad, w;
        logic seen;
        cnt = 0;
        bad = 0;
        w = 0;
        seen = 1'b0;
        step(1);
        device_reset_n = 1'b1;
        while (w < 3000 && !(seen && init_busy !== 1'b1)) begin
            @(posedge clock);
            w++;
            if (init_busy === 1'b1) seen = 1'b1;
            if (init_we === 1'b1) begin
                if (init_index !== cnt[10:0]) bad++;
                cnt++;
            end
        end
        chk_val("init steps", `HPI_INIT_COUNT, cnt);
        chk_val("init order errors", 0, bad);
        step(1);
        chk_flag("standby after init", 1'b0, standby);
    endtask

    task automatic t_host();
        logic [7:0] rd;
        logic drv, seen;
        int n, rel, r0;
        r0 = req_cnt;
        hpi_host_model_i.stray(20, seen);
        chk_flag("ack without select", 1'b0, seen);
        chk_val("core req without select", r0, req_cnt);
        ack_delay = 1;
        hpi_host_model_i.access(1'b0, 11'h123, 8'h5a, rd, drv, n, rel);
        chk_flag("write ack", 1'b1, n != 0);
        chk_val("write addr", 11'h123, last_addr);
        chk_val("write data", 8'h5a, last_wd);
        chk_flag("write dir", 1'b1, last_wr);
        chk_flag("write bus drive", 1'b0, drv);
        chk_flag("write release", 1'b1, rel < 8);
        ack_delay = 6;
        core_data = 8'hc3;
        hpi_host_model_i.access(1'b1, 11'h7fe, 8'h00, rd, drv, n, rel);
        chk_flag("read ack", 1'b1, n > 6);
        chk_val("read data", 8'hc3, rd);
        chk_flag("read dir", 1'b0, last_wr);
        chk_flag("read bus drive", 1'b1, drv);
        chk_flag("read release", 1'b1, rel < 8);
    endtask

    task automatic t_irq();
        logic [7:0] rd;
        logic drv;
        int n, rel, r0;
        step(1);
        irq_push = 1'b1;
        irq_code = 8'h11;
        step(1);
        irq_code = 8'h22;
        step(1);
        irq_push = 1'b0;
        step(2);
        chk_flag("irq pending", 1'b0, interrupt_request_oe_n);
        r0 = req_cnt;
        hpi_host_model_i.access(1'b1, `HPI_IRQ_FIFO_ADDR, 8'h00, rd, drv, n, rel);
        chk_val("first entry", 8'h11, rd);
        chk_flag("irq one left", 1'b0, interrupt_request_oe_n);
        hpi_host_model_i.access(1'b1, `HPI_IRQ_FIFO_ADDR, 8'h00, rd, drv, n, rel);
        chk_val("second entry", 8'h22, rd);
        chk_flag("irq released", 1'b1, interrupt_request_oe_n);
        hpi_host_model_i.access(1'b1, `HPI_IRQ_FIFO_ADDR, 8'h00, rd, drv, n, rel);
        chk_val("empty queue", `HPI_EMPTY_CODE, rd);
        chk_val("queue reads bypass core", r0, req_cnt);
        irq_push = 1'b1;
        irq_code = 8'h33;
        step(`HPI_FIFO_DEPTH);
        irq_push = 1'b0;
        step(3);
        chk_flag("queue full", 1'b1, irq_full);
        device_reset_n = 1'b0;
        step(8);
        chk_flag("standby on reset", 1'b1, standby);
        chk_flag("irq cleared by reset", 1'b1, interrupt_request_oe_n);
        t_init();
    endtask

    task automatic tck_cycle(input logic m, input logic d, output logic b);
        logic v;
        step(1);
        tms = m;
        tdi = d;
        step(2);
        tck = 1'b1;
        v = tdo;
        step(8);
        chk_flag("tdo while test clock high", v, tdo);
        tck = 1'b0;
        step(8);
        b = tdo;
    endtask

    task automatic to_shift(output logic b);
        tck_cycle(1'b0, 1'b1, b);
        tck_cycle(1'b1, 1'b1, b);
        tck_cycle(1'b0, 1'b1, b);
        tck_cycle(1'b0, 1'b1, b);
    endtask

    task automatic t_tap();
        logic [39:0] got;
        logic [31:0] id;
        logic [7:0]  pat;
        logic        b;
        id = `HPI_IDCODE;
        pat = 8'hb4;
        step(1);
        test_reset_n = 1'b0;
        step(1);
        chk_flag("tdo after test reset", 1'b1, tdo_oe_n);
        test_reset_n = 1'b1;
        to_shift(b);
        got[0] = b;
        for (int i = 1; i < 40; i++) begin
            tck_cycle(1'b0, pat[(i - 1) % 8], b);
            got[i] = b;
            chk_flag("tdo drive in shift", 1'b0, tdo_oe_n);
        end
        chk_val("id scan", {pat, id}, got);
        test_reset_n = 1'b0;
        step(1);
        chk_flag("tdo on mid-scan reset", 1'b1, tdo_oe_n);
        test_reset_n = 1'b1;
        to_shift(b);
        chk_flag("id bit after reset", id[0], b);
        tck_cycle(1'b1, 1'b1, b);
        chk_flag("tdo after shift exit", 1'b1, tdo_oe_n);
    endtask

    initial begin
        clock = 1'b0;
        rstn = 1'b0;
        device_reset_n = 1'b0;
        irq_push = 1'b0;
        irq_code = 8'h00;
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
        test_reset_n = 1'b0;
        core_data = 8'h00;
        ack_delay = 1;
        failures = 0;
        total_checks = 0;
        step(2);
        rstn = 1'b1;
        test_reset_n = 1'b1;
        t_standby();
        t_init();
        t_host();
        t_irq();
        t_tap();
        stop_test();
    end

    // a hang counts as a failure
    initial begin
        #100000;
        failures++;
        stop_test();
    end
endmodule
